// ==== src/battery_balance_sequencer.v ====
// Overview of operation
// - Stack select bits: 00 shutdown, 01 three, 10 two, 11 four batteries.
// - Mode bit low runs timed balancing, high runs nonstop_operation balancing.
// - Nothing starts until the boost capacitor ready input is high.
// - Timed mode drives the balancing status low while actively balancing.
// - Each pass starts at battery one: bottom switches on, 50 ms, then sample.
// - Sample within threshold: bottom switches off, move on, no top switches.
// - Sample above threshold: top switches also turn on for that battery.
// - After top switches turn on, wait 50 ms before monitoring the comparator.
// - Battery stays connected until within threshold or per-battery timeout.
// - Step end: all switches off, 50 ms gap, then next battery, for all.
// - Timed balance reached: done low, status released, enter off state.
// - Balanced after stack size plus one consecutive bottom-only within samples.
// - Timed mode caps run at on-time, then off for off-time, then resumes.
// - Balancing status is high impedance in off state or shutdown.
// - Nonstop_operation mode has no on/off states, runs until shutdown, status low.
// - Nonstop_operation mode always uses top switches and ends steps on timeout only.
// - Nonstop_operation mode still drives done low once balanced while cycling on.
// - Undervoltage or overvoltage detection drives its fault output low.
// - Faults never alter the switch sequencing.
// - A fault that clears returns its output to high impedance.
// - Two indicators show the active battery: 00, 01, 11, 10.
`include "battery_balance_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module battery_balance_sequencer #(
  parameter integer TICK_CYCLES   = `TICK_CYCLES,
  parameter integer SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Analog front end inputs
  input  wire        term_exceeds,
  input  wire        uv_detect,
  input  wire        ov_detect,
  input  wire        boost_cap_ready,
  // Switch drivers, one bit per battery
  output reg  [3:0]  bottom_sw_en,
  output reg  [3:0]  top_sw_en,
  // Threshold select to the comparator
  output reg         threshold_sel_lo,
  output reg         threshold_sel_hi,
  // Open-drain status pins, enable low while pulling low; done_n is driven directly
  output reg         balancing_active_n,
  output reg         balancing_active_oe_n,
  output reg         undervoltage_fault_n,
  output reg         undervoltage_fault_oe_n,
  output reg         overvoltage_fault_n,
  output reg         overvoltage_fault_oe_n,
  output reg         done_n,
  // Active battery indicators
  output reg         active_cell_ind_hi,
  output reg         active_cell_ind_lo
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_BOTTOM = 3'h1;
  localparam [2:0] S_TOPSET = 3'h2;
  localparam [2:0] S_MON    = 3'h3;
  localparam [2:0] S_GAP    = 3'h4;
  localparam [2:0] S_OFF    = 3'h5;

  // --------------------------------------------------------------------------
  // Registers and bus state
  // --------------------------------------------------------------------------
  reg  [4:0]  ctrl_q;
  reg  [15:0] cell_tmo_q;
  reg  [15:0] on_time_q;
  reg  [15:0] off_time_q;
  reg         aw_held_q;
  reg  [7:0]  aw_addr_q;
  reg         w_held_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [1:0]  idx_q;
  reg  [1:0]  idx_d;
  reg  [2:0]  consec_q;
  reg  [2:0]  consec_d;
  reg         done_q;
  reg         done_d;
  reg  [22:0] phase_q;
  reg  [16:0] tick_div_q;
  reg  [15:0] cell_ms_q;
  reg  [15:0] run_ms_q;
  reg  [31:0] status_w;

  wire        tick;
  wire        enabled;
  wire        nonstop;
  wire [1:0]  last_idx;
  wire [2:0]  need_consec;
  wire        settled;
  wire        cell_expired;
  wire        run_expired;
  wire        do_write;
  wire        balancing;

  // --------------------------------------------------------------------------
  // Mode and stack decode
  // --------------------------------------------------------------------------
  // stack size decode
  assign enabled     = ctrl_q[`CTRL_SEL_A] | ctrl_q[`CTRL_SEL_B];
  assign last_idx    = {ctrl_q[`CTRL_SEL_A], ~ctrl_q[`CTRL_SEL_A] | ctrl_q[`CTRL_SEL_B]};
  assign nonstop     = ctrl_q[`CTRL_NONSTOP];
  // one more clean sample than batteries
  assign need_consec = {1'b0, last_idx} + 3'h2;

  // --------------------------------------------------------------------------
  // Timebase
  // --------------------------------------------------------------------------
  // counters from the block clock
  assign tick         = (tick_div_q == TICK_CYCLES[16:0] - 17'h00001);
  assign settled      = (phase_q >= SETTLE_CYCLES[22:0] - 23'h000001);
  assign cell_expired = (cell_ms_q >= cell_tmo_q);
  assign run_expired  = nonstop ? (1'b0) :
                        (state_q == S_OFF) ? (run_ms_q >= off_time_q) :
                        (run_ms_q >= on_time_q);
  assign balancing    = (state_q != S_IDLE) && (state_q != S_OFF);

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // analog inputs used as synchronous bits
  always @* begin
    state_d  = state_q;
    idx_d    = idx_q;
    consec_d = consec_q;
    done_d   = done_q;
    case (state_q)
      S_IDLE: begin
        idx_d    = 2'h0;
        consec_d = 3'h0;
        if (boost_cap_ready) begin
          state_d = S_BOTTOM;
        end
      end
      S_BOTTOM: begin
        if (settled) begin
          if (!term_exceeds) begin
            consec_d = consec_q + 3'h1;
            if (consec_q + 3'h1 >= need_consec) begin
              // balance also flagged in nonstop_operation mode
              done_d   = 1'b1;
              consec_d = 3'h0;
            end
          end else begin
            consec_d = 3'h0;
            if (nonstop) begin
              done_d = 1'b0;
            end
          end
          // nonstop_operation mode always uses top switches
          if (term_exceeds || nonstop) begin
            state_d = S_TOPSET;
          end else if (!nonstop && consec_q + 3'h1 >= need_consec) begin
            state_d = S_OFF;
          end else begin
            state_d = S_GAP;
            idx_d   = (idx_q == last_idx) ? 2'h0 : idx_q + 2'h1;
          end
        end
      end
      S_TOPSET: begin
        if (cell_expired) begin
          state_d = S_GAP;
          idx_d   = (idx_q == last_idx) ? 2'h0 : idx_q + 2'h1;
        end else if (settled) begin
          state_d = S_MON;
        end
      end
      S_MON: begin
        if (cell_expired || (!nonstop && !term_exceeds)) begin
          state_d = S_GAP;
          idx_d   = (idx_q == last_idx) ? 2'h0 : idx_q + 2'h1;
        end
      end
      S_GAP: begin
        if (settled) begin
          state_d = S_BOTTOM;
        end
      end
      S_OFF: begin
        // off-time then resume a fresh pass
        if (run_expired) begin
          state_d  = S_GAP;
          idx_d    = 2'h0;
          consec_d = 3'h0;
          done_d   = 1'b0;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (balancing && run_expired) begin
      state_d  = S_OFF;
      consec_d = 3'h0;
    end
    if (!enabled) begin
      state_d  = S_IDLE;
      done_d   = 1'b0;
      consec_d = 3'h0;
      idx_d    = 2'h0;
    end
  end

  // fault inputs do not feed the sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= S_IDLE;
      idx_q      <= 2'h0;
      consec_q   <= 3'h0;
      done_q     <= 1'b0;
      phase_q    <= 23'h000000;
      tick_div_q <= 17'h00000;
      cell_ms_q  <= 16'h0000;
      run_ms_q   <= 16'h0000;
    end else begin
      state_q    <= state_d;
      idx_q      <= idx_d;
      consec_q   <= consec_d;
      done_q     <= done_d;
      tick_div_q <= tick ? 17'h00000 : tick_div_q + 17'h00001;
      phase_q    <= (state_d != state_q) ? 23'h000000 : phase_q + 23'h000001;
      if (state_d == S_BOTTOM || state_d == S_GAP || state_d == S_IDLE) begin
        cell_ms_q <= 16'h0000;
      end else if (tick && cell_ms_q != 16'hFFFF) begin
        cell_ms_q <= cell_ms_q + 16'h0001;
      end
      if (state_d == S_IDLE || (state_d == S_OFF) != (state_q == S_OFF)) begin
        run_ms_q <= 16'h0000;
      end else if (tick && run_ms_q != 16'hFFFF) begin
        run_ms_q <= run_ms_q + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin outputs
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      bottom_sw_en            <= 4'h0;
      top_sw_en               <= 4'h0;
      threshold_sel_lo        <= 1'b0;
      threshold_sel_hi        <= 1'b0;
      balancing_active_n      <= 1'b0;
      balancing_active_oe_n   <= 1'b1;
      undervoltage_fault_n    <= 1'b0;
      undervoltage_fault_oe_n <= 1'b1;
      overvoltage_fault_n     <= 1'b0;
      overvoltage_fault_oe_n  <= 1'b1;
      done_n                  <= 1'b1;
      active_cell_ind_hi      <= 1'b0;
      active_cell_ind_lo      <= 1'b0;
    end else begin
      // bottom switches of the active battery
      bottom_sw_en <= (state_d == S_BOTTOM || state_d == S_TOPSET || state_d == S_MON) ?
                      (4'h1 << idx_d) : 4'h0;
      top_sw_en    <= (state_d == S_TOPSET || state_d == S_MON) ? (4'h1 << idx_d) : 4'h0;
      threshold_sel_lo <= ctrl_q[`CTRL_THR_LO];
      threshold_sel_hi <= ctrl_q[`CTRL_THR_HI];
      // pull low while balancing in timed mode
      // released in off state and shutdown
      // always pulled low in nonstop_operation mode
      balancing_active_oe_n <= ~(enabled && (nonstop ||
                                 (state_d != S_IDLE && state_d != S_OFF)));
      // fault pins pull low on detection
      // released when the fault goes away
      undervoltage_fault_oe_n <= ~uv_detect;
      overvoltage_fault_oe_n  <= ~ov_detect;
      done_n <= ~done_d;
      // gray code of the active battery
      active_cell_ind_hi <= idx_d[1];
      active_cell_ind_lo <= idx_d[1] ^ idx_d[0];
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  // Address and data are latched separately so either may come first.
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  function [15:0] merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  strb;
    begin
      merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
    end
  endfunction

  always @* begin
    status_w = 32'h00000000;
    status_w[`STAT_STATE_LSB +: 3] = state_q;
    status_w[`STAT_CELL_LSB +: 2]  = idx_q;
    status_w[`STAT_DONE]           = done_q;
    status_w[`STAT_BAL]            = ~balancing_active_oe_n;
    status_w[`STAT_UV]             = uv_detect;
    status_w[`STAT_OV]             = ov_detect;
    status_w[`STAT_CMP]            = term_exceeds;
    status_w[`STAT_BOOST]          = boost_cap_ready;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q        <= `RST_CTRL;
      cell_tmo_q    <= `RST_CELL_TMO;
      on_time_q     <= `RST_ON_TIME;
      off_time_q    <= `RST_OFF_TIME;
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_held_q      <= 1'b0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr_q)
          `ADDR_CTRL: begin
            ctrl_q <= w_strb_q[0] ? w_data_q[4:0] : ctrl_q;
          end
          `ADDR_CELL_TMO: begin
            cell_tmo_q <= merge(cell_tmo_q, w_data_q[15:0], w_strb_q[1:0]);
          end
          `ADDR_ON_TIME: begin
            on_time_q <= merge(on_time_q, w_data_q[15:0], w_strb_q[1:0]);
          end
          `ADDR_OFF_TIME: begin
            off_time_q <= merge(off_time_q, w_data_q[15:0], w_strb_q[1:0]);
          end
          `ADDR_STATUS: s_axi_bresp <= `RESP_OKAY;
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_CTRL:     s_axi_rdata <= {27'h0, ctrl_q};
          `ADDR_CELL_TMO: s_axi_rdata <= {16'h0, cell_tmo_q};
          `ADDR_ON_TIME:  s_axi_rdata <= {16'h0, on_time_q};
          `ADDR_OFF_TIME: s_axi_rdata <= {16'h0, off_time_q};
          `ADDR_STATUS:   s_axi_rdata <= status_w;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ==== src/battery_balance_regs.vh ====
`ifndef BATTERY_BALANCE_REGS_VH
`define BATTERY_BALANCE_REGS_VH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_CTRL        8'h00
`define ADDR_CELL_TMO    8'h04
`define ADDR_ON_TIME     8'h08
`define ADDR_OFF_TIME    8'h0C
`define ADDR_STATUS      8'h10
// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_SEL_A       0
`define CTRL_SEL_B       1
`define CTRL_NONSTOP     2
`define CTRL_THR_LO      3
`define CTRL_THR_HI      4
`define CTRL_WIDTH       5
// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define STAT_STATE_LSB   0
`define STAT_CELL_LSB    4
`define STAT_DONE        8
`define STAT_BAL         9
`define STAT_UV          10
`define STAT_OV          11
`define STAT_CMP         12
`define STAT_BOOST       13
// ----------------------------------------------------------------------------
// Reset values, times in milliseconds
// ----------------------------------------------------------------------------
`define RST_CTRL         5'h00
`define RST_CELL_TMO     16'h03E8
`define RST_ON_TIME      16'hEA60
`define RST_OFF_TIME     16'hEA60
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ          100
`define TICK_US          1000
`define SETTLE_MS        50
`define TICK_CYCLES      (`CLK_MHZ * `TICK_US)
`define SETTLE_CYCLES    (`SETTLE_MS * 1000 * `CLK_MHZ)
// ----------------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------------
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ==== testbench/analog_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Comparator model: a connected battery loaded as imbalanced reads above threshold until
// its top switches have carried charge for FIX_CYCLES plus one cycles while fix_en is high.
// ----------------------------------------------------------------
module analog_front_model #(
  parameter integer FIX_CYCLES = 10
) (
  input  wire logic       aclk,
  input  wire logic [3:0] bottom_sw_en,
  input  wire logic [3:0] top_sw_en,
  input  wire logic [3:0] imbalance,
  input  wire logic       load,
  input  wire logic       fix_en,
  output var  logic       term_exceeds
);
  logic [3:0] off_q    = 4'h0;
  logic       toggle_q = 1'b0;
  int         cnt_q    = 0;
  always @(posedge aclk) begin
    toggle_q <= ~toggle_q;
    if (load) begin
      off_q <= imbalance;
    end else if (|top_sw_en && fix_en) begin
      cnt_q <= cnt_q + 1;
      if (cnt_q == FIX_CYCLES) begin
        off_q <= off_q & ~top_sw_en;
      end
    end else begin
      cnt_q <= 0;
    end
  end
  // With nothing connected the comparator output means nothing, so it wanders.
  always_comb term_exceeds = (|bottom_sw_en) ? |(off_q & bottom_sw_en) : toggle_q;
endmodule
`default_nettype wire

// ==== testbench/battery_balance_sequencer_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module battery_balance_sequencer_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        uv_detect,
  input wire logic        ov_detect,
  input wire logic        boost_cap_ready,
  input wire logic [3:0]  bottom_sw_en,
  input wire logic [3:0]  top_sw_en,
  input wire logic        balancing_active_oe_n,
  input wire logic        undervoltage_fault_oe_n,
  input wire logic        overvoltage_fault_oe_n,
  input wire logic        active_cell_ind_hi,
  input wire logic        active_cell_ind_lo
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_bot_held;
    ##1 $stable(bottom_sw_en) [*8];
  endsequence
  sequence s_top_held;
    ##1 $stable(top_sw_en) [*8];
  endsequence
  sequence s_gap;
    (bottom_sw_en == 4'h0 && top_sw_en == 4'h0) [*8];
  endsequence
  property p_bot_settle;
    $rose(|bottom_sw_en) |-> s_bot_held;
  endproperty
  a_bot_settle: assert property (p_bot_settle)
    else $error("bottom switches moved early");
  property p_top_settle;
    $rose(|top_sw_en) |-> s_top_held;
  endproperty
  a_top_settle: assert property (p_top_settle)
    else $error("top switches moved early");
  property p_top_pair;
    (|top_sw_en) |-> top_sw_en == bottom_sw_en;
  endproperty
  a_top_pair: assert property (p_top_pair)
    else $error("top without matching bottom");
  property p_gap;
    $fell(|bottom_sw_en) |=> s_gap;
  endproperty
  a_gap: assert property (p_gap)
    else $error("gap too short");
  property p_ind;
    (|bottom_sw_en) |-> {active_cell_ind_hi, active_cell_ind_lo} ==
      {bottom_sw_en[2] | bottom_sw_en[3], bottom_sw_en[1] | bottom_sw_en[2]};
  endproperty
  a_ind: assert property (p_ind)
    else $error("indicator mismatch");
  property p_bal_low;
    (|bottom_sw_en) && $past(|bottom_sw_en) |-> !balancing_active_oe_n;
  endproperty
  a_bal_low: assert property (p_bal_low)
    else $error("status released while connected");
  property p_uv_set;
    uv_detect |=> !undervoltage_fault_oe_n;
  endproperty
  a_uv_set: assert property (p_uv_set)
    else $error("undervoltage pin not low");
  property p_ov_clear;
    !ov_detect |=> overvoltage_fault_oe_n;
  endproperty
  a_ov_clear: assert property (p_ov_clear)
    else $error("overvoltage pin not released");
  property p_no_boost;
    !boost_cap_ready |-> bottom_sw_en == 4'h0;
  endproperty
  a_no_boost: assert property (p_no_boost)
    else $error("switching before boost ready");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data dropped");
endmodule
bind battery_balance_sequencer battery_balance_sequencer_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .uv_detect(uv_detect),
  .ov_detect(ov_detect), .boost_cap_ready(boost_cap_ready), .bottom_sw_en(bottom_sw_en),
  .top_sw_en(top_sw_en), .balancing_active_oe_n(balancing_active_oe_n),
  .undervoltage_fault_oe_n(undervoltage_fault_oe_n),
  .overvoltage_fault_oe_n(overvoltage_fault_oe_n),
  .active_cell_ind_hi(active_cell_ind_hi), .active_cell_ind_lo(active_cell_ind_lo));
`default_nettype wire

// ==== testbench/tb.sv ====
`include "battery_balance_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, term, thr_lo, thr_hi;
  logic [1:0]  bresp, rresp;
  logic        boost = 1'b0, uv = 1'b0, ov = 1'b0, load = 1'b0, fix_en = 1'b0;
  logic [3:0]  imbalance = 4'h0, bot, top;
  logic        bal_n, bal_oe_n, uv_n, uv_oe_n, ov_n, ov_oe_n, done_n, ind_hi, ind_lo;
  logic        bot_any, top_any;
  logic [1:0]  ind_tab [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  int          err_count = 0, check_count = 0;
  assign bot_any = |bot;
  assign top_any = |top;
  // Short tick and settle keep each pass to a few hundred cycles.
  battery_balance_sequencer #(.TICK_CYCLES(10), .SETTLE_CYCLES(20)) u_battery_balance_sequencer (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .term_exceeds(term), .uv_detect(uv), .ov_detect(ov), .boost_cap_ready(boost),
    .bottom_sw_en(bot), .top_sw_en(top), .threshold_sel_lo(thr_lo), .threshold_sel_hi(thr_hi),
    .balancing_active_n(bal_n), .balancing_active_oe_n(bal_oe_n),
    .undervoltage_fault_n(uv_n), .undervoltage_fault_oe_n(uv_oe_n),
    .overvoltage_fault_n(ov_n), .overvoltage_fault_oe_n(ov_oe_n), .done_n(done_n),
    .active_cell_ind_hi(ind_hi), .active_cell_ind_lo(ind_lo));
  analog_front_model #(.FIX_CYCLES(10)) u_analog_front_model (
    .aclk(aclk), .bottom_sw_en(bot), .top_sw_en(top), .imbalance(imbalance),
    .load(load), .fix_en(fix_en), .term_exceeds(term));
  always #5 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        chk(bresp, er);
      end
    end while (bready);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        chk(rdata, ed);
        chk(rresp, er);
      end
    end while (rready);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk(n < 3000, 1'b1);
  endtask
  task automatic rst(input logic [3:0] imb, input logic fx);
    @(posedge aclk);
    {aresetn, boost, uv, ov, load} <= 5'b00001;
    imbalance <= imb;
    fix_en <= fx;
    repeat (2) @(posedge aclk);
    {aresetn, load} <= 2'b10;
  endtask
  task automatic go(input logic [31:0] ctrl, input logic [31:0] tmo);
    wr(`ADDR_OFF_TIME, 32'h3, `RESP_OKAY);
    wr(`ADDR_CELL_TMO, tmo, `RESP_OKAY);
    wr(`ADDR_CTRL, ctrl, `RESP_OKAY);
    boost <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rst(4'h0, 1'b0);
    rd(`ADDR_CTRL, 32'h0, `RESP_OKAY);
    rd(`ADDR_CELL_TMO, 32'h3E8, `RESP_OKAY);
    rd(`ADDR_ON_TIME, 32'hEA60, `RESP_OKAY);
    rd(`ADDR_OFF_TIME, 32'hEA60, `RESP_OKAY);
    rd(8'h14, 32'h0, `RESP_SLVERR);
    wr(8'h14, 32'h5, `RESP_SLVERR);
    wr(`ADDR_STATUS, 32'hFFFF, `RESP_OKAY);
    wr(`ADDR_CELL_TMO, 32'h1234, `RESP_OKAY);
    rd(`ADDR_CELL_TMO, 32'h1234, `RESP_OKAY);
  endtask
  task automatic t_shutdown();
    rst(4'h0, 1'b0);
    go(32'h18, 32'h5);
    repeat (60) @(posedge aclk);
    chk(bot, 4'h0);
    chk({thr_hi, thr_lo, bal_n, bal_oe_n}, 4'hD);
  endtask
  task automatic t_timed_bal();
    int n, k;
    rst(4'h0, 1'b0);
    wr(`ADDR_OFF_TIME, 32'h3, `RESP_OKAY);
    wr(`ADDR_CTRL, 32'h3, `RESP_OKAY);
    repeat (50) @(posedge aclk);
    chk(bot, 4'h0);
    boost <= 1'b1;
    for (k = 0; k < 5; k++) begin
      wait_lvl(bot_any, 1'b1, n);
      chk(bot, 4'h1 << (k % 4));
      chk({ind_hi, ind_lo}, ind_tab[k % 4]);
      chk(done_n, 1'b1);
      wait_lvl(bot_any, 1'b0, n);
      chk(n >= 19 && n <= 23, 1'b1);
    end
    wait_lvl(done_n, 1'b0, n);
    chk(n < 60, 1'b1);
    chk(bal_oe_n, 1'b1);
    wait_lvl(bot_any, 1'b1, n);
    chk(n >= 30 && n <= 80, 1'b1);
    chk(bot, 4'h1);
  endtask
  task automatic t_top(input logic fx, input int lo, input int hi);
    int n;
    rst(4'h2, fx);
    go(32'h2, 32'h5);
    wait_lvl(top_any, 1'b1, n);
    chk(top, 4'h2);
    wait_lvl(top_any, 1'b0, n);
    chk(n >= lo && n <= hi, 1'b1);
  endtask
  task automatic t_cont();
    int n, k;
    rst(4'h0, 1'b1);
    go(32'h5, 32'h5);
    for (k = 0; k < 4; k++) begin
      wait_lvl(bot_any, 1'b1, n);
      chk(bot, 4'h1 << (k % 3));
      uv <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({uv_oe_n, uv_n}, 2'b00);
      uv <= 1'b0;
      ov <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({uv_oe_n, ov_oe_n, ov_n}, 3'b100);
      ov <= 1'b0;
      wait_lvl(top_any, 1'b1, n);
      chk(bal_oe_n, 1'b0);
      wait_lvl(top_any, 1'b0, n);
      chk(n >= 39 && n <= 62, 1'b1);
    end
    wait_lvl(done_n, 1'b0, n);
    wait_lvl(bot_any, 1'b1, n);
    chk({done_n, bal_oe_n}, 2'b00);
  endtask
  task automatic t_ontime();
    int n;
    rst(4'h1, 1'b0);
    wr(`ADDR_ON_TIME, 32'h7, `RESP_OKAY);
    go(32'h2, 32'h3E8);
    wait_lvl(top_any, 1'b1, n);
    wait_lvl(bal_oe_n, 1'b1, n);
    chk(n >= 30 && n <= 65, 1'b1);
    chk({bot, done_n}, 5'h01);
    wait_lvl(bot_any, 1'b1, n);
    chk(n >= 30 && n <= 75, 1'b1);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    t_regs();
    t_shutdown();
    t_timed_bal();
    t_top(1'b1, 19, 24);
    t_top(1'b0, 39, 62);
    t_cont();
    t_ontime();
    print_verdict();
  end
  initial begin
    #200000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
